// >>> common/tsrp_pkg.sv
// Constants and carrier types for the tester short register port.
// Assumes a 24-bit command word and a 24-bit data word from the host.
package tsrp_pkg;

   // ************
   // Command word fields
   // ************
   localparam int unsigned OP_HI   = 23;
   localparam int unsigned OP_LO   = 18;
   localparam int unsigned FN_HI   = 17;
   localparam int unsigned FN_LO   = 15;
   localparam int unsigned REG_HI  = 13;
   localparam int unsigned REG_LO  = 8;
   localparam int unsigned UNIT_HI = 7;
   localparam int unsigned UNIT_LO = 0;

   localparam logic [5:0] OP_REGISTER = 6'h06;
   localparam logic [2:0] FN_READ     = 3'h6;
   localparam logic [2:0] FN_WRITE    = 3'h4;
   localparam logic [2:0] FN_SPECIAL  = 3'h2;
   localparam logic [7:0] UNIT_TESTER = 8'h50;

   // ************
   // Register numbers
   // ************
   localparam logic [5:0] REG_MODE  = 6'h01;
   localparam logic [5:0] REG_STAT  = 6'h02;
   localparam logic [5:0] REG_INSTR = 6'h03;
   localparam logic [5:0] REG_INDC  = 6'h0d;

   // ************
   // Mode and status bit positions, reset values
   // ************
   localparam int unsigned MB_SHORT_RST = 0;
   localparam int unsigned MB_LONG_RST  = 1;
   localparam int unsigned MB_DMA       = 9;
   localparam int unsigned MB_LAST_FN   = 10;
   localparam int unsigned MB_TRIP_FAIL = 12;
   localparam int unsigned MB_FUNC_FAIL = 13;
   localparam int unsigned MB_PASS      = 14;
   localparam int unsigned SB_TRIP_EN   = 8;
   localparam int unsigned SB_STOP_EN   = 12;
   localparam int unsigned SB_STOP_INT  = 13;
   localparam int unsigned SB_IN_PROC   = 14;

   localparam logic [15:0] MODE_RESET    = 16'h0000;
   localparam logic [15:0] STAT_RESET    = 16'h0000;
   localparam logic [15:0] STAT_SET_MASK = 16'h0055;
   localparam logic [15:0] STAT_SPC_CLR  = 16'h3fff;
   localparam logic [23:0] INSTR_RESET   = 24'h000000;
   localparam logic [15:0] INDC_RESET    = 16'h0000;

   // Long-bus action codes in instruction bits 23:22
   localparam logic [1:0] LB_WR_HOLD = 2'h0;
   localparam logic [1:0] LB_WR_EXEC = 2'h1;
   localparam logic [1:0] LB_READ    = 2'h2;
   localparam int unsigned LB_DATA_W = 15;

   // ************
   // Types
   // ************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WDATA,
      ST_LBREAD,
      ST_BUSY
   } tsrp_state_e;

   typedef struct packed {
      logic       trip_fail;
      logic       func_fail;
      logic       pass;
      logic       last_fn;
      logic       inc_cmp;
      logic       delay_done;
      logic       trap;
      logic       fail;
      logic       stop;
      logic [2:0] supply_trip;
      logic       busy;
   } tsrp_evt_s;

   typedef struct packed {
      logic        strobe;
      logic [1:0]  action;
      logic [23:0] word;
   } tsrp_lb_s;

endpackage

// >>> hw/tsrp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs.
// Assumes the inputs are slow levels; no pulse stretching is done.
`timescale 1ns/10ps
`default_nettype none

module tsrp_sync #(
   parameter int unsigned W = 13
) (
   input  wire logic         clk,    // System clock
   input  wire logic         rst_n,  // Synchronised reset
   input  wire logic [W-1:0] d_in,   // Asynchronous levels
   output var  logic [W-1:0] q_out   // Synchronised levels
);

   logic [W-1:0] meta_reg;

   // ************
   // One two-flop chain per bit
   // ************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // First stage feeds only the second stage
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               q_out[i]    <= 1'b0;
            end else begin
               meta_reg[i] <= d_in[i];
               q_out[i]    <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// >>> hw/tsrp_top.sv
// Tester short register port: decodes host register commands.
// Assumes host command, data and long-bus answers are on clk.
// Tester event inputs are asynchronous and are synchronised here.
//
// Summary of operation
// R1: Op code bits 23:18 must be 06
// R2: Function 6 read, 4 write, 2 special
// R3: Bits 13:8 pick one of 64 registers
// R4: Accept only unit number octal 120
// R5: Host sends one eight-digit command word
// R6: Read command returns register contents
// R7: Write command followed by data word
// R8: Special runs action, moves no data
// R9: Mode bits 0,1 reset short, long
// R10: Mode bits 2-6 hold mode selections
// R11: Mode bit 10 last function register
// R12: Mode bits 12,13 trip, functional fail
// R13: Pass bit 14 cleared by fails
// R14: Special to mode clears whole register
// R15: Pending reported only when enabled
// R16: Supply trips reported only with bit 8
// R17: Status holds interrupt-in-process bit
// R18: Marked status bits set on reset
// R19: Special to status clears bits 0-13
// R20: Instruction register buffers long-bus words
// R21: Long-bus words carry rank address bits
// R22: Bits 23:22 pick long-bus action
// R23: DMA write-exec counts, waits not busy
// R24: Foreign or no-op commands do nothing
`timescale 1ns/10ps
`default_nettype none

module tsrp_top #(
   parameter int unsigned EVT_W = 13
) (
   input  wire logic              clk,        // 10 MHz clock
   input  wire logic              arst_n,     // Async reset
   input  wire logic              cmd_valid,  // Command strobe
   input  wire logic [23:0]       cmd_word,   // Command word
   input  wire logic              wr_valid,   // Write data strobe
   input  wire logic [23:0]       wr_data,    // Write data word
   input  wire tsrp_pkg::tsrp_evt_s evt_in,   // Tester events
   input  wire logic              lb_rvalid,  // Long-bus answer
   input  wire logic [14:0]       lb_rdata,   // Long-bus answer data
   output var  logic              cmd_ready,  // Idle, can take command
   output var  logic              rd_valid,   // Read answer strobe
   output var  logic [23:0]       rd_data,    // Read answer word
   output var  logic [15:0]       mode_out,   // Mode register
   output var  logic              long_rst,   // Long register reset
   output var  tsrp_pkg::tsrp_lb_s lb_req,    // Long-bus request
   output var  logic [15:0]       ind_count   // Instruction number
);

   // ************
   // Reset release and event synchronisation
   // ************
   logic                rst_meta_reg;
   logic                rst_n;
   tsrp_pkg::tsrp_evt_s evt;
   logic [EVT_W-1:0]    evt_bits;

   // Reset asserts at once and releases after two edges
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   tsrp_sync #(
      .W     (EVT_W)
   ) tsrp_sync_inst (
      .clk   (clk),
      .rst_n (rst_n),
      .d_in  (evt_in),
      .q_out (evt_bits)
   );

   assign evt = tsrp_pkg::tsrp_evt_s'(evt_bits);

   // ************
   // Command decode
   // ************
   logic       cmd_hit;
   logic [2:0] cmd_fn;
   logic [5:0] cmd_reg;

   // R1: op code match
   // R4: unit number match
   assign cmd_hit = cmd_valid
      && (cmd_word[tsrp_pkg::OP_HI:tsrp_pkg::OP_LO]
          == tsrp_pkg::OP_REGISTER)
      && (cmd_word[tsrp_pkg::UNIT_HI:tsrp_pkg::UNIT_LO]
          == tsrp_pkg::UNIT_TESTER);
   // R2: function field
   assign cmd_fn  = cmd_word[tsrp_pkg::FN_HI:tsrp_pkg::FN_LO];
   // R3: register number
   assign cmd_reg = cmd_word[tsrp_pkg::REG_HI:tsrp_pkg::REG_LO];

   // ************
   // State
   // ************
   tsrp_pkg::tsrp_state_e state_reg;
   tsrp_pkg::tsrp_state_e state_next;
   logic [5:0]            sel_reg;
   logic [5:0]            sel_next;
   logic [15:0]           mode_reg;
   logic [15:0]           mode_next;
   logic [15:0]           stat_reg;
   logic [15:0]           stat_next;
   logic [23:0]           instr_reg;
   logic [23:0]           instr_next;
   logic [15:0]           ind_reg;
   logic [15:0]           ind_next;
   logic                  rd_valid_next;
   logic [23:0]           rd_data_next;
   logic                  long_rst_next;
   logic                  ready_next;
   tsrp_pkg::tsrp_lb_s    lb_reg;
   tsrp_pkg::tsrp_lb_s    lb_next;
   logic [15:0]           stat_view;

   // ************
   // Status as seen by a read
   // ************
   // R15: pending shown only when enabled
   // R16: trips gated by trip enable
   // R17: in-process and spare pass through
   always_comb begin
      stat_view      = stat_reg;
      stat_view[1]   = stat_reg[1] & stat_reg[0];
      stat_view[3]   = stat_reg[3] & stat_reg[2];
      stat_view[5]   = stat_reg[5] & stat_reg[4];
      stat_view[7]   = stat_reg[7] & stat_reg[6];
      stat_view[11:9] = stat_reg[11:9]
         & {3{stat_reg[tsrp_pkg::SB_TRIP_EN]}};
      stat_view[tsrp_pkg::SB_STOP_INT] =
         stat_reg[tsrp_pkg::SB_STOP_INT]
         & stat_reg[tsrp_pkg::SB_STOP_EN];
   end

   // ************
   // Next-state logic
   // ************
   always_comb begin
      state_next    = state_reg;
      sel_next      = sel_reg;
      mode_next     = mode_reg;
      stat_next     = stat_reg;
      instr_next    = instr_reg;
      ind_next      = ind_reg;
      rd_valid_next = 1'b0;
      rd_data_next  = 24'h000000;
      long_rst_next = 1'b0;
      lb_next       = lb_reg;
      lb_next.strobe = 1'b0;

      case (state_reg)
         tsrp_pkg::ST_IDLE: begin
            // R24: other commands are ignored
            if (cmd_hit) begin
               if (cmd_fn == tsrp_pkg::FN_READ) begin
                  // R6: return addressed register
                  rd_valid_next = 1'b1;
                  if (cmd_reg == tsrp_pkg::REG_MODE) begin
                     rd_data_next = {8'h00, mode_reg};
                  end else if (cmd_reg == tsrp_pkg::REG_STAT) begin
                     rd_data_next = {8'h00, stat_view};
                  end else if (cmd_reg == tsrp_pkg::REG_INSTR) begin
                     rd_data_next = instr_reg;
                  end else if (cmd_reg == tsrp_pkg::REG_INDC) begin
                     rd_data_next = {8'h00, ind_reg};
                  end else begin
                     rd_data_next = 24'h000000;
                  end
               end else if (cmd_fn == tsrp_pkg::FN_WRITE) begin
                  // R7: wait for the data word
                  sel_next   = cmd_reg;
                  state_next = tsrp_pkg::ST_WDATA;
               end else if (cmd_fn == tsrp_pkg::FN_SPECIAL) begin
                  // R8: action only, no data moves
                  if (cmd_reg == tsrp_pkg::REG_MODE) begin
                     // R14: clear mode register
                     mode_next = 16'h0000;
                  end else if (cmd_reg == tsrp_pkg::REG_STAT) begin
                     // R19: clear low fourteen bits
                     stat_next = stat_reg & ~tsrp_pkg::STAT_SPC_CLR;
                  end else if (cmd_reg == tsrp_pkg::REG_INDC) begin
                     ind_next = ind_reg + 16'h0001;
                  end
               end
            end
         end

         tsrp_pkg::ST_WDATA: begin
            if (wr_valid) begin
               state_next = tsrp_pkg::ST_IDLE;
               if (sel_reg == tsrp_pkg::REG_MODE) begin
                  // R10: mode selections stored
                  // R11: last function flag writable
                  // R12: fail flags writable
                  mode_next = wr_data[15:0];
               end else if (sel_reg == tsrp_pkg::REG_STAT) begin
                  stat_next = wr_data[15:0];
               end else if (sel_reg == tsrp_pkg::REG_INDC) begin
                  ind_next = wr_data[15:0];
               end else if (sel_reg == tsrp_pkg::REG_INSTR) begin
                  // R20: buffer word toward long bus
                  // R21: rank and register bits carried
                  instr_next     = wr_data;
                  lb_next.strobe = 1'b1;
                  lb_next.word   = wr_data;
                  // R22: action from bits 23:22
                  lb_next.action = wr_data[23:22];
                  if (wr_data[23:22] == tsrp_pkg::LB_READ) begin
                     state_next = tsrp_pkg::ST_LBREAD;
                  end else if (wr_data[23:22] == tsrp_pkg::LB_WR_EXEC
                               && mode_reg[tsrp_pkg::MB_DMA]) begin
                     // R23: count then wait not busy
                     ind_next   = ind_reg + 16'h0001;
                     state_next = tsrp_pkg::ST_BUSY;
                  end
               end
            end
         end

         tsrp_pkg::ST_LBREAD: begin
            // R22: read answer lands in bits 0-14
            if (lb_rvalid) begin
               instr_next[tsrp_pkg::LB_DATA_W-1:0] = lb_rdata;
               state_next = tsrp_pkg::ST_IDLE;
            end
         end

         tsrp_pkg::ST_BUSY: begin
            // R23: hold off until tester idle
            if (!evt.busy) begin
               state_next = tsrp_pkg::ST_IDLE;
            end
         end

         default: begin
            state_next = tsrp_pkg::ST_IDLE;
         end
      endcase

      // R9: long reset is a one-cycle pulse
      if (mode_next[tsrp_pkg::MB_LONG_RST]) begin
         long_rst_next = 1'b1;
         mode_next[tsrp_pkg::MB_LONG_RST] = 1'b0;
      end

      // R9: short reset restores mode, status, instruction
      // R18: marked status bits come up set
      if (mode_next[tsrp_pkg::MB_SHORT_RST]) begin
         mode_next  = tsrp_pkg::MODE_RESET;
         stat_next  = tsrp_pkg::STAT_RESET | tsrp_pkg::STAT_SET_MASK;
         instr_next = tsrp_pkg::INSTR_RESET;
      end

      // Hardware events win over a same-cycle clear
      // R11: last function register follows tester
      if (evt.last_fn) begin
         mode_next[tsrp_pkg::MB_LAST_FN] = 1'b1;
      end
      // R12: fail flags set by tester
      if (evt.trip_fail) begin
         mode_next[tsrp_pkg::MB_TRIP_FAIL] = 1'b1;
      end
      if (evt.func_fail) begin
         mode_next[tsrp_pkg::MB_FUNC_FAIL] = 1'b1;
      end
      if (evt.pass) begin
         mode_next[tsrp_pkg::MB_PASS] = 1'b1;
      end
      // R13: any fail clears pass
      if (mode_next[tsrp_pkg::MB_TRIP_FAIL]
          || mode_next[tsrp_pkg::MB_FUNC_FAIL]) begin
         mode_next[tsrp_pkg::MB_PASS] = 1'b0;
      end

      // R15: pending flags latched from events
      if (evt.inc_cmp) begin
         stat_next[1] = 1'b1;
      end
      if (evt.delay_done) begin
         stat_next[3] = 1'b1;
      end
      if (evt.trap) begin
         stat_next[5] = 1'b1;
      end
      if (evt.fail) begin
         stat_next[7] = 1'b1;
      end
      // R16: supply trips latched
      stat_next[11:9] = stat_next[11:9] | evt.supply_trip;
      if (evt.stop) begin
         stat_next[tsrp_pkg::SB_STOP_INT] = 1'b1;
      end

      ready_next = (state_next == tsrp_pkg::ST_IDLE);
   end

   // ************
   // Registers
   // ************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= tsrp_pkg::ST_IDLE;
         sel_reg   <= 6'h00;
         mode_reg  <= tsrp_pkg::MODE_RESET;
         stat_reg  <= tsrp_pkg::STAT_RESET | tsrp_pkg::STAT_SET_MASK;
         instr_reg <= tsrp_pkg::INSTR_RESET;
         ind_reg   <= tsrp_pkg::INDC_RESET;
         rd_valid  <= 1'b0;
         rd_data   <= 24'h000000;
         long_rst  <= 1'b0;
         cmd_ready <= 1'b0;
         lb_reg    <= '0;
      end else begin
         state_reg <= state_next;
         sel_reg   <= sel_next;
         mode_reg  <= mode_next;
         stat_reg  <= stat_next;
         instr_reg <= instr_next;
         ind_reg   <= ind_next;
         rd_valid  <= rd_valid_next;
         rd_data   <= rd_data_next;
         long_rst  <= long_rst_next;
         cmd_ready <= ready_next;
         lb_reg    <= lb_next;
      end
   end

   // ************
   // Outputs straight from registers
   // ************
   assign mode_out  = mode_reg;
   assign lb_req    = lb_reg;
   assign ind_count = ind_reg;

endmodule

`default_nettype wire

// >>> dv/tsrp_asserts.sv
// Checker for the tester short register port, bound into its top.
// Assumes one clock domain and only the top module's ports.
`timescale 1ns/10ps
`default_nettype none

module tsrp_asserts (
   input wire logic                clk,       // Clock
   input wire logic                arst_n,    // Async reset
   input wire logic                cmd_valid, // Command strobe
   input wire logic [23:0]         cmd_word,  // Command word
   input wire logic                wr_valid,  // Data strobe
   input wire tsrp_pkg::tsrp_evt_s evt_in,    // Tester events
   input wire logic                cmd_ready, // Port idle
   input wire logic                rd_valid,  // Read answer
   input wire logic [15:0]         mode_out,  // Mode register
   input wire logic                long_rst,  // Long reset pulse
   input wire tsrp_pkg::tsrp_lb_s  lb_req,    // Long-bus request
   input wire logic [15:0]         ind_count  // Instruction number
);
   // ************
   // Helpers
   // ************
   logic       ok_cmd;
   logic [2:0] fn;
   logic [5:0] rg;
   logic [2:0] quiet_reg;

   // Command that the port must take
   assign ok_cmd = cmd_valid && cmd_ready
                   && cmd_word[23:18] == tsrp_pkg::OP_REGISTER
                   && cmd_word[7:0] == tsrp_pkg::UNIT_TESTER;
   assign fn = cmd_word[17:15];
   assign rg = cmd_word[13:8];

   // Cycles since events last active; synced events lag the pins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         quiet_reg <= 3'h0;
      end else if (evt_in != '0) begin
         quiet_reg <= 3'h0;
      end else if (quiet_reg != 3'h7) begin
         quiet_reg <= quiet_reg + 3'h1;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!arst_n);

   // ************
   // Assertions
   // ************
   // read answered
   chk_read_answer: assert property (
      ok_cmd && fn == tsrp_pkg::FN_READ |=> rd_valid)
      else $error("read command gave no answer");
   chk_answer_cause: assert property (
      rd_valid |-> $past(ok_cmd && fn == tsrp_pkg::FN_READ))
      else $error("answer without accepted read");
   chk_foreign_quiet: assert property (
      cmd_valid && cmd_ready && (!ok_cmd || fn == 3'h0)
      |=> !rd_valid && !lb_req.strobe && $stable(ind_count))
      else $error("ignored command had an effect");
   chk_write_wait: assert property (
      ok_cmd && fn == tsrp_pkg::FN_WRITE |=> !cmd_ready)
      else $error("ready while waiting for data");
   chk_mode_clear: assert property (
      ok_cmd && fn == tsrp_pkg::FN_SPECIAL && rg == tsrp_pkg::REG_MODE
      && quiet_reg > 3'h3 |=> mode_out == 16'h0000)
      else $error("mode not cleared by special");
   chk_ind_special: assert property (
      ok_cmd && fn == tsrp_pkg::FN_SPECIAL && rg == tsrp_pkg::REG_INDC
      |=> ind_count == $past(ind_count) + 16'h0001)
      else $error("counter not stepped by special");
   chk_lb_action: assert property (
      lb_req.strobe |-> lb_req.action == lb_req.word[23:22]
      && (lb_req.action != tsrp_pkg::LB_READ || !cmd_ready))
      else $error("long-bus action or read wait wrong");
   chk_long_pulse: assert property (
      long_rst |=> !long_rst)
      else $error("long reset longer than one cycle");
   chk_pass_clear: assert property (
      (mode_out[12] || mode_out[13]) && !wr_valid |=> !mode_out[14])
      else $error("pass kept while fail flagged");

   cover property (rd_valid);
   cover property (long_rst);
   cover property (lb_req.strobe && lb_req.action == tsrp_pkg::LB_READ);
endmodule

bind tsrp_top tsrp_asserts tsrp_asserts_inst (
   .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
   .cmd_word(cmd_word), .wr_valid(wr_valid), .evt_in(evt_in),
   .cmd_ready(cmd_ready), .rd_valid(rd_valid), .mode_out(mode_out),
   .long_rst(long_rst), .lb_req(lb_req), .ind_count(ind_count)
);
`default_nettype wire

// >>> dv/tsrp_host.sv
// Host model: sends register commands and data words to the port.
// Assumes the port clock; drives only on falling edges.
`timescale 1ns/10ps
`default_nettype none

module tsrp_host (
   input  wire logic        clk,       // Port clock
   input  wire logic        cmd_ready, // Port idle
   input  wire logic        rd_valid,  // Read answer strobe
   input  wire logic [23:0] rd_data,   // Read answer word
   output var  logic        cmd_valid, // Command strobe
   output var  logic [23:0] cmd_word,  // Command word
   output var  logic        wr_valid,  // Data strobe
   output var  logic [23:0] wr_data    // Data word
);
   // ************
   // Bus cycles
   // ************
   initial begin
      cmd_valid = 1'h0;
      cmd_word  = 24'h000000;
      wr_valid  = 1'h0;
      wr_data   = 24'h000000;
   end

   // One command, optional data after gap cycles, then any answer
   task automatic xfer(input logic [5:0] op, input logic [2:0] fn,
                       input logic [5:0] rg, input logic [7:0] un,
                       input logic [23:0] d, input int gap,
                       output logic got, output logic [23:0] q);
      int n;
      n   = 0;
      got = 1'h0;
      q   = 24'h000000;
      @(negedge clk);
      while (cmd_ready !== 1'h1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      cmd_word  <= {op, fn, 1'h0, rg, un};
      cmd_valid <= 1'h1;
      @(negedge clk);
      cmd_valid <= 1'h0;
      cmd_word  <= ~cmd_word;
      if (fn == tsrp_pkg::FN_WRITE) begin
         repeat (gap) @(negedge clk);
         wr_valid <= 1'h1;
         wr_data  <= d;
      end
      for (int k = 0; k < 3; k++) begin
         if (rd_valid === 1'h1) begin
            got = 1'h1;
            q   = rd_data;
         end
         @(negedge clk);
         wr_valid <= 1'h0;
         wr_data  <= ~d;
      end
   endtask
endmodule
`default_nettype wire

// >>> dv/tsrp_top_tb.sv
// Self-checking bench for the tester short register port.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tsrp_top_tb;
   // ************
   // Signals
   // ************
   typedef struct packed {
      logic [2:0]  fn;
      logic [5:0]  rg;
      logic [23:0] d;
      logic        got;
      logic [23:0] q;
   } tsrp_row_s;

   localparam logic [2:0] RD = tsrp_pkg::FN_READ;
   localparam logic [2:0] WR = tsrp_pkg::FN_WRITE;
   localparam logic [2:0] SP = tsrp_pkg::FN_SPECIAL;
   localparam logic [5:0] RMODE = tsrp_pkg::REG_MODE;
   localparam logic [5:0] RSTAT = tsrp_pkg::REG_STAT;
   localparam logic [5:0] RINST = tsrp_pkg::REG_INSTR;

   logic                clk, arst_n, cmd_valid, wr_valid, lb_rvalid;
   logic                cmd_ready, rd_valid, long_rst;
   logic                lr_seen = 1'h0;
   logic [23:0]         cmd_word, wr_data, rd_data;
   logic [15:0]         mode_out, ind_count;
   logic [14:0]         lb_rdata;
   tsrp_pkg::tsrp_evt_s evt;
   tsrp_pkg::tsrp_lb_s  lb_req;
   tsrp_row_s           r;
   int                  err_count = 0;
   int                  checked = 0;

   // Plain cases: function, register, data, answer expected, word
   tsrp_row_s rows [0:18] = '{
      '{RD, RMODE, 24'h0, 1'h1, 24'h0}, '{RD, RSTAT, 24'h0, 1'h1, 24'h55},
      '{WR, RMODE, 24'h474, 1'h0, 24'h0}, '{RD, RMODE, 24'h0, 1'h1, 24'h474},
      '{WR, RMODE, 24'h4000, 1'h0, 24'h0}, '{RD, RMODE, 24'h0, 1'h1, 24'h4000},
      '{WR, RMODE, 24'h6000, 1'h0, 24'h0}, '{RD, RMODE, 24'h0, 1'h1, 24'h2000},
      '{WR, RMODE, 24'h1000, 1'h0, 24'h0}, '{RD, RMODE, 24'h0, 1'h1, 24'h1000},
      '{SP, RMODE, 24'h0, 1'h0, 24'h0}, '{RD, RMODE, 24'h0, 1'h1, 24'h0},
      '{3'h0, RMODE, 24'h0, 1'h0, 24'h0}, '{WR, RINST, 24'h12ab, 1'h0, 24'h0},
      '{RD, RINST, 24'h0, 1'h1, 24'h12ab}, '{RD, 6'h3f, 24'h0, 1'h1, 24'h0},
      '{WR, RSTAT, 24'h9155, 1'h0, 24'h0}, '{SP, RSTAT, 24'h0, 1'h0, 24'h0},
      '{RD, RSTAT, 24'h0, 1'h1, 24'h8000}
   };

   tsrp_top tsrp_top_inst (
      .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .wr_valid(wr_valid), .wr_data(wr_data),
      .evt_in(evt), .lb_rvalid(lb_rvalid), .lb_rdata(lb_rdata),
      .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .mode_out(mode_out), .long_rst(long_rst), .lb_req(lb_req),
      .ind_count(ind_count)
   );

   tsrp_host tsrp_host_inst (
      .clk(clk), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .wr_valid(wr_valid), .wr_data(wr_data)
   );

   // ************
   // Tasks
   // ************
   task automatic chk1(input string nm, input logic e, input logic s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chkw(input string nm, input logic [23:0] e,
                       input logic [23:0] s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_of_test();
      if (err_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One host transfer and its answer
   task automatic cmd(input logic [2:0] fn, input logic [5:0] rg,
                      input logic [23:0] d, input logic eg,
                      input logic [23:0] eq,
                      input logic [7:0] un = tsrp_pkg::UNIT_TESTER,
                      input logic [5:0] op = tsrp_pkg::OP_REGISTER,
                      input int gap = 0);
      logic        got;
      logic [23:0] q;
      tsrp_host_inst.xfer(op, fn, rg, un, d, gap, got, q);
      chk1("rd_valid", eg, got);
      if (eg === 1'h1) chkw("rd_data", eq, q);
   endtask

   // ************
   // Processes
   // ************
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   initial begin
      #1000000;
      err_count++;
      end_of_test();
   end

   initial begin
      lb_rvalid = 1'h0;
      lb_rdata  = 15'h0000;
      forever begin
         @(negedge clk);
         if (lb_req.strobe === 1'h1
             && lb_req.action === tsrp_pkg::LB_READ) begin
            repeat (3) @(negedge clk);
            lb_rdata  <= 15'h5a5a;
            lb_rvalid <= 1'h1;
            @(negedge clk);
            lb_rvalid <= 1'h0;
            lb_rdata  <= 15'h25a5;
         end
      end
   end

   // Remembers a long reset pulse
   always @(posedge clk) if (long_rst === 1'h1) lr_seen <= 1'h1;

   initial begin
      evt    = 13'h0000;
      arst_n = 1'h0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      arst_n = 1'h1;
      for (int i = 0; i < 19; i++) begin
         r = rows[i];
         cmd(r.fn, r.rg, r.d, r.got, r.q);
      end
      cmd(WR, RMODE, 24'h00fc, 1'h0, 24'h0, 8'h51);
      cmd(RD, RMODE, 24'h0, 1'h0, 24'h0, 8'h50, 6'h07);
      cmd(RD, RMODE, 24'h0, 1'h1, 24'h0);
      evt = 13'h01fe;
      cmd(WR, RSTAT, 24'h0, 1'h0, 24'h0);
      cmd(RD, RSTAT, 24'h0, 1'h1, 24'h0);
      cmd(WR, RSTAT, 24'h1155, 1'h0, 24'h0);
      cmd(RD, RSTAT, 24'h0, 1'h1, 24'h3fff);
      evt = 13'h0000;
      repeat (4) @(negedge clk);
      cmd(WR, RMODE, 24'h1, 1'h0, 24'h0);
      cmd(RD, RSTAT, 24'h0, 1'h1, 24'h55);
      cmd(WR, RMODE, 24'h2, 1'h0, 24'h0);
      chk1("long_rst", 1'h1, lr_seen);
      cmd(WR, RINST, 24'h800000, 1'h0, 24'h0);
      cmd(RD, RINST, 24'h0, 1'h1, 24'h805a5a);
      cmd(WR, RMODE, 24'h200, 1'h0, 24'h0);
      chkw("mode_out", 24'h200, {8'h00, mode_out});
      evt = 13'h0001;
      cmd(WR, RINST, 24'h400007, 1'h0, 24'h0, 8'h50, 6'h06, 2);
      chkw("ind_count", 24'h1, {8'h00, ind_count});
      chk1("cmd_ready", 1'h0, cmd_ready);
      evt = 13'h0000;
      cmd(SP, tsrp_pkg::REG_INDC, 24'h0, 1'h0, 24'h0);
      chkw("ind_count", 24'h2, {8'h00, ind_count});
      arst_n = 1'h0;
      @(negedge clk);
      chkw("mode_out", 24'h0, {8'h00, mode_out});
      arst_n = 1'h1;
      cmd(RD, RSTAT, 24'h0, 1'h1, 24'h55);
      end_of_test();
   end
endmodule
`default_nettype wire
